/* File: src/fbh_cfg.svh */
// Timing and field constants for the flash bus host.
// Assumes a 10 MHz clk; all counts are whole cycles of it.
`ifndef FBH_CFG_SVH
`define FBH_CFG_SVH
// ----------------------------------------
// Bus timing
// ----------------------------------------
`define FBH_CLK_NS 100
`define FBH_ACCESS_NS 120
`define FBH_ACCESS_CYC ((`FBH_ACCESS_NS + `FBH_CLK_NS - 1) / `FBH_CLK_NS)
`define FBH_WPULSE_NS 100
`define FBH_WPULSE_CYC ((`FBH_WPULSE_NS + `FBH_CLK_NS - 1) / `FBH_CLK_NS)
`define FBH_RESET_NS 500
`define FBH_RESET_CYC ((`FBH_RESET_NS + `FBH_CLK_NS - 1) / `FBH_CLK_NS)
`define FBH_RECOVER_NS 200
`define FBH_RECOVER_CYC ((`FBH_RECOVER_NS + `FBH_CLK_NS - 1) / `FBH_CLK_NS)
// ----------------------------------------
// Protect address fields
// ----------------------------------------
`define FBH_PROT_SEL_BIT 6
`define FBH_PROT_A1_BIT 1
`define FBH_PROT_A0_BIT 0
`endif

/* File: src/fbh_pkg.sv */
// Types shared by the flash bus host and its pin stage.
// Assumes fbh_cfg.svh is included by the modules that need counts.
package fbh_pkg;
   typedef enum logic [2:0] {
      FBH_OP_READ = 3'h0,
      FBH_OP_WRITE = 3'h1,
      FBH_OP_RESET = 3'h2,
      FBH_OP_PROTECT = 3'h3,
      FBH_OP_UNPROTECT = 3'h4
   } fbh_op_e;
   typedef enum logic [2:0] {
      FBH_ST_IDLE = 3'h0,
      FBH_ST_SETUP = 3'h1,
      FBH_ST_READ = 3'h2,
      FBH_ST_WRITE = 3'h3,
      FBH_ST_RESET = 3'h4,
      FBH_ST_RECOVER = 3'h5
   } fbh_state_e;
   typedef struct packed {
      fbh_op_e op;
      logic byteMode;
      logic [20:0] addr;
      logic [15:0] wdata;
   } fbh_req_s;
   // Pin levels driven to the flash; pin names ending in N are active low
   typedef struct packed {
      logic chipSelN;
      logic outGateN;
      logic writeStrobeN;
      logic resetN;
      logic elevated_voltage_level;
      logic byteWordSel;
      logic [19:0] addr;
      logic [15:0] dataOut;
      logic [15:0] dataOe;
   } fbh_pins_s;
   typedef struct packed {
      fbh_state_e state;
      logic [3:0] count;
      fbh_req_s req;
      fbh_pins_s pins;
      logic [15:0] rdata;
      logic done;
   } fbh_ctl_s;
endpackage

/* File: src/fbh_data_sync.sv */
// Three-stage input synchroniser for the flash data pins.
// Assumes the pins are asynchronous to clk; a change counts once stages two and three agree.
`timescale 1ns/1ps
module fbh_data_sync
   import fbh_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] syncOut
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] held;
   } fbh_sync_s;
   fbh_sync_s st_reg;
   fbh_sync_s st_next;
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pinIn;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // Per-bit filter: only a level seen twice passes
      for (int i = 0; i < WIDTH; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.held[i] = st_reg.s3[i];
         end
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign syncOut = st_reg.held;
endmodule

/* File: src/fbh_host.sv */
// Host controller driving a parallel flash through its bus-operation pins.
// Assumes a user side on the same clk and pins wired to the flash by the testbench.
// Operation
// - Read: select and gate low, strobe high
// - Write: strobe and select low, gate high
// - Protect: elevated reset, A6=L A1=H A0=L
// - Unprotect: same, but A6 high
`timescale 1ns/1ps
`include "fbh_cfg.svh"
module fbh_host
   import fbh_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic reqValid,
   output logic reqReady,
   input wire fbh_req_s req,
   output logic rspValid,
   output logic [15:0] rspData,
   output fbh_pins_s pins,
   input wire logic [15:0] flashDataIn
);
   // ----------------------------------------
   // Counts
   // ----------------------------------------
   localparam logic [3:0] ACCESS_CYC = 4'(`FBH_ACCESS_CYC);
   localparam logic [3:0] WPULSE_CYC = 4'(`FBH_WPULSE_CYC);
   localparam logic [3:0] RESET_CYC = 4'(`FBH_RESET_CYC);
   localparam logic [3:0] RECOVER_CYC = 4'(`FBH_RECOVER_CYC);
   // Extra cycles cover the three-stage data synchroniser
   localparam logic [3:0] READ_CYC = 4'(`FBH_ACCESS_CYC + 3);

   fbh_ctl_s st_reg;
   fbh_ctl_s st_next;
   logic [15:0] dataSync;

   fbh_data_sync #(
      .WIDTH(16)
   ) uSync (
      .clk(clk),
      .srst(srst),
      .pinIn(flashDataIn),
      .syncOut(dataSync)
   );

   function automatic fbh_pins_s idlePins(input logic byteMode);
      fbh_pins_s p;
      p = '0;
      p.chipSelN = 1'b1;
      p.outGateN = 1'b1;
      p.writeStrobeN = 1'b1;
      p.resetN = 1'b1;
      p.byteWordSel = ~byteMode;
      return p;
   endfunction

   // Address pins, and in byte mode line fifteen carries the extra low bit
   function automatic fbh_pins_s addrPins(input fbh_pins_s p, input fbh_req_s r);
      fbh_pins_s q;
      q = p;
      if (r.byteMode) begin
         q.addr = r.addr[20:1];
         q.dataOut[15] = r.addr[0];
         q.dataOe[15] = 1'b1;
      end else begin
         q.addr = r.addr[19:0];
      end
      return q;
   endfunction

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      case (st_reg.state)
         FBH_ST_IDLE: begin
            st_next.pins = idlePins(st_reg.req.byteMode);
            if (reqValid) begin
               st_next.req = req;
               st_next.count = '0;
               if (req.op == FBH_OP_RESET) begin
                  st_next.pins.resetN = 1'b0;
                  st_next.state = FBH_ST_RESET;
               end else begin
                  st_next.pins = addrPins(idlePins(req.byteMode), req);
                  st_next.state = FBH_ST_SETUP;
               end
            end
         end
         FBH_ST_SETUP: begin
            st_next.count = '0;
            st_next.pins.chipSelN = 1'b0;
            if (st_reg.req.op == FBH_OP_READ) begin
               // Release the data lines so the flash may drive them; in byte mode
               // line fifteen stays driven because it carries the low address bit
               st_next.pins.dataOe = {st_reg.req.byteMode, 15'h0000};
               st_next.pins.outGateN = 1'b0;
               st_next.state = FBH_ST_READ;
            end else begin
               st_next.pins.writeStrobeN = 1'b0;
               if (st_reg.req.op == FBH_OP_WRITE) begin
                  if (st_reg.req.byteMode) begin
                     st_next.pins.dataOut[7:0] = st_reg.req.wdata[7:0];
                     st_next.pins.dataOe[7:0] = 8'hff;
                  end else begin
                     st_next.pins.dataOut = st_reg.req.wdata;
                     st_next.pins.dataOe = 16'hffff;
                  end
               end else begin
                  // Protect cycles carry data on the low byte and fixed address bits
                  st_next.pins.elevated_voltage_level = 1'b1;
                  st_next.pins.addr[`FBH_PROT_SEL_BIT] = (st_reg.req.op == FBH_OP_UNPROTECT);
                  st_next.pins.addr[`FBH_PROT_A1_BIT] = 1'b1;
                  st_next.pins.addr[`FBH_PROT_A0_BIT] = 1'b0;
                  st_next.pins.dataOut[7:0] = st_reg.req.wdata[7:0];
                  st_next.pins.dataOe[7:0] = 8'hff;
               end
               st_next.state = FBH_ST_WRITE;
            end
         end
         FBH_ST_READ: begin
            st_next.count = st_reg.count + 4'h1;
            if (st_reg.count == READ_CYC - 4'h1) begin
               // Byte mode uses only the low eight lines
               st_next.rdata = st_reg.req.byteMode ? {8'h00, dataSync[7:0]} : dataSync;
               st_next.done = 1'b1;
               st_next.pins = idlePins(st_reg.req.byteMode);
               st_next.state = FBH_ST_IDLE;
            end
         end
         FBH_ST_WRITE: begin
            st_next.count = st_reg.count + 4'h1;
            if (st_reg.count == WPULSE_CYC - 4'h1) begin
               // Strobe rises first; data and address hold one more cycle
               st_next.pins.writeStrobeN = 1'b1;
               st_next.pins.chipSelN = 1'b1;
               st_next.count = '0;
               st_next.state = FBH_ST_RECOVER;
            end
         end
         FBH_ST_RESET: begin
            st_next.count = st_reg.count + 4'h1;
            if (st_reg.count == RESET_CYC - 4'h1) begin
               st_next.pins.resetN = 1'b1;
               st_next.count = '0;
               st_next.state = FBH_ST_RECOVER;
            end
         end
         FBH_ST_RECOVER: begin
            st_next.pins = idlePins(st_reg.req.byteMode);
            st_next.count = st_reg.count + 4'h1;
            if (st_reg.count == RECOVER_CYC - 4'h1) begin
               st_next.done = 1'b1;
               st_next.state = FBH_ST_IDLE;
            end
         end
         default: begin
            st_next.state = FBH_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= '0;
         st_reg.pins.chipSelN <= 1'b1;
         st_reg.pins.outGateN <= 1'b1;
         st_reg.pins.writeStrobeN <= 1'b1;
         st_reg.pins.resetN <= 1'b1;
         st_reg.pins.byteWordSel <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reqReady = (st_reg.state == FBH_ST_IDLE);
   assign rspValid = st_reg.done;
   assign rspData = st_reg.rdata;
   assign pins = st_reg.pins;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence readGate;
      !pins.chipSelN && !pins.outGateN;
   endsequence

   a_read_levels: assert property (@(posedge clk) disable iff (srst)
      readGate |-> pins.writeStrobeN && pins.resetN && pins.dataOe[14:0] == 15'h0)
      else $error("read cycle with bad strobe, reset or driven data");
   a_write_levels: assert property (@(posedge clk) disable iff (srst)
      !pins.writeStrobeN |-> !pins.chipSelN && pins.outGateN)
      else $error("write strobe without select or with gate low");
   a_write_pulse: assert property (@(posedge clk) disable iff (srst)
      $fell(pins.writeStrobeN) |-> !pins.writeStrobeN [*1] ##1 pins.writeStrobeN)
      else $error("write pulse length wrong");
   a_prot_addr: assert property (@(posedge clk) disable iff (srst)
      pins.elevated_voltage_level && !pins.writeStrobeN |->
         pins.addr[1] && !pins.addr[0] && pins.outGateN)
      else $error("protect cycle address bits wrong");
   a_unprot_sel: assert property (@(posedge clk) disable iff (srst)
      pins.elevated_voltage_level && !pins.writeStrobeN |->
         pins.addr[6] == (st_reg.req.op == FBH_OP_UNPROTECT))
      else $error("protect select bit wrong");
   a_reset_pulse: assert property (@(posedge clk) disable iff (srst)
      $fell(pins.resetN) |-> !pins.resetN [*5] ##1 pins.resetN)
      else $error("reset pulse length wrong");
   a_reset_quiet: assert property (@(posedge clk) disable iff (srst)
      !pins.resetN |-> pins.chipSelN && pins.writeStrobeN && pins.outGateN)
      else $error("bus active during reset pulse");
   a_byte_a1: assert property (@(posedge clk) disable iff (srst)
      !pins.chipSelN && !pins.byteWordSel |-> pins.dataOe[15] && pins.dataOe[14:8] == 7'h0)
      else $error("byte mode line fifteen not driven as address");
   a_read_done: assert property (@(posedge clk) disable iff (srst)
      $fell(pins.outGateN) |-> ##5 rspValid)
      else $error("read answer not on time");
endmodule

/* File: tb/fbh_flash_model.sv */
// Behavioural flash seen from its pins: array, command latches, autoselect.
// Assumes pins move on clk rising edges; it acts on levels settled at the falling edge.
`timescale 1ns/1ps
module fbh_flash_model
   import fbh_pkg::*;
#(
   parameter logic [7:0] ID_CODE = 8'h3c // Arbitrary value
) (
   input wire logic clk,
   input wire fbh_pins_s pins,
   input wire logic [15:0] bus,
   output logic [15:0] devData,
   output logic [15:0] devOe
);
   logic [15:0] mem [int];
   logic [15:0] w;
   logic [19:0] a;
   logic autoSel = 1'b0;
   logic progArm = 1'b0;
   logic eraseArm = 1'b0;
   logic rd;
   int protCnt = 0;
   int unprotCnt = 0;
   int clash = 0;
   assign a = pins.addr;
   assign rd = !pins.chipSelN && !pins.outGateN && pins.writeStrobeN && pins.resetN && !pins.elevated_voltage_level;
   // -----------------------------
   // Read side, no drive otherwise
   // -----------------------------
   always_comb begin
      w = mem.exists(a) ? mem[a] : (a[15:0] ^ 16'h5a3c);
      devData = 16'h0000;
      devOe = 16'h0000;
      if (rd) begin
         if (autoSel) begin
            devData = {8'h00, ID_CODE};
            devOe = 16'h00ff;
         end else if (pins.byteWordSel) begin
            devData = w;
            devOe = 16'hffff;
         end else begin
            devData = {8'h00, bus[15] ? w[15:8] : w[7:0]};
            devOe = 16'h00ff;
         end
      end
   end
   // Writes are one clock long, so one action per strobe
   always @(negedge clk) begin
      clash += $countones(pins.dataOe & devOe);
      if (!pins.resetN && !pins.elevated_voltage_level) begin
         autoSel <= 1'b0;
         progArm <= 1'b0;
         eraseArm <= 1'b0;
      end else if (!pins.chipSelN && !pins.writeStrobeN && pins.outGateN) begin
         if (pins.elevated_voltage_level) begin
            if (a[1:0] == 2'b10 && a[6]) unprotCnt++;
            if (a[1:0] == 2'b10 && !a[6]) protCnt++;
         end else if (progArm) begin
            progArm <= 1'b0;
            mem[a] = w;
            if (pins.byteWordSel) mem[a] = bus;
            else if (bus[15]) mem[a][15:8] = bus[7:0];
            else mem[a][7:0] = bus[7:0];
         end else begin
            progArm <= bus[7:0] == 8'ha0;
            eraseArm <= bus[7:0] == 8'h80;
            // Sector erase: every word whose upper address bits match goes back to unwritten
            if (eraseArm && bus[7:0] == 8'h30) begin
               foreach (mem[k]) begin
                  if (k[19:15] == a[19:15]) mem[k] = k[15:0] ^ 16'h5a3c;
               end
            end
            if (bus[7:0] == 8'h90) autoSel <= 1'b1;
            if (bus[7:0] == 8'hf0) autoSel <= 1'b0;
         end
      end
   end
endmodule

/* File: tb/fbh_host_tb.sv */
// Self-checking bench for the flash bus host against a behavioural flash.
// Assumes 10 MHz clk; lower address half holds unwritten array, upper half takes programs.
`timescale 1ns/1ps
module fbh_host_tb;
   import fbh_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic reqValid = 1'b0;
   logic flt = 1'b0;
   logic reqReady, rspValid;
   fbh_req_s req = '0;
   fbh_pins_s pins;
   logic [15:0] rspData, bus, devData, devOe, got, d;
   logic [20:0] ad;
   int miscompares = 0;
   int checked = 0;
   fbh_host i_dut(.clk(clk), .srst(srst), .reqValid(reqValid), .reqReady(reqReady), .req(req),
      .rspValid(rspValid), .rspData(rspData), .pins(pins), .flashDataIn(bus));
   fbh_flash_model i_flash(.clk(clk), .pins(pins), .bus(bus), .devData(devData), .devOe(devOe));
   // Undriven lines toggle so a stale value never reads as good
   assign bus = (pins.dataOe & pins.dataOut) | (~pins.dataOe & devOe & devData)
      | (~pins.dataOe & ~devOe & {16{flt}});
   initial forever #50 clk = ~clk;
   always @(posedge clk) flt <= ~flt;
   // -----------------------------
   // Tasks and expectations
   // -----------------------------
   function automatic logic [15:0] arr(input logic [20:0] ba, input logic bm);
      logic [15:0] v;
      v = (bm ? ba[16:1] : ba[15:0]) ^ 16'h5a3c;
      return bm ? {8'h00, ba[0] ? v[15:8] : v[7:0]} : v;
   endfunction
   task automatic chk(input logic [15:0] exp, input logic [15:0] act);
      checked++;
      if (act !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
      end
   endtask
   task automatic tally_and_finish();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic op(input fbh_op_e o, input logic bm, input logic [20:0] a, input logic [15:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{o, bm, a, wd};
      reqValid <= 1'b1;
      do begin
         @(negedge clk);
         n++;
      end while (!reqReady && n < 50);
      @(posedge clk);
      reqValid <= 1'b0;
      do begin
         @(negedge clk);
         n++;
      end while (!rspValid && n < 100);
      if (!rspValid) begin
         miscompares++;
         tally_and_finish();
      end
      got = rspData;
   endtask
   // -----------------------------
   // Main sequence
   // -----------------------------
   initial begin
      void'($urandom(42));
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         ad = (i == 0) ? 21'h0 : (i == 1) ? 21'h07ffff : 21'($urandom()) & 21'h07ffff;
         op(FBH_OP_READ, i[0], ad, 16'h0000);
         chk(arr(ad, i[0]), got);
      end
      $display("test array read done");
      ad = 21'h080000 | (21'($urandom()) & 21'h07ffff);
      d = 16'($urandom());
      op(FBH_OP_WRITE, 1'b0, ad, 16'h00a0);
      op(FBH_OP_WRITE, 1'b0, ad, d);
      op(FBH_OP_READ, 1'b0, ad, 16'h0000);
      chk(d, got);
      op(FBH_OP_WRITE, 1'b1, {ad[19:0], 1'b1}, 16'h00a0);
      op(FBH_OP_WRITE, 1'b1, {ad[19:0], 1'b1}, {8'h00, ~d[15:8]});
      op(FBH_OP_READ, 1'b0, ad, 16'h0000);
      chk({~d[15:8], d[7:0]}, got);
      op(FBH_OP_WRITE, 1'b0, 21'h0, 16'h0080);
      op(FBH_OP_WRITE, 1'b0, {1'b0, ad[19:15], ~ad[14:0]}, 16'h0030);
      op(FBH_OP_READ, 1'b0, ad, 16'h0000);
      chk(arr(ad, 1'b0), got);
      $display("test program done");
      op(FBH_OP_WRITE, 1'b0, 21'h0, 16'h0090);
      op(FBH_OP_READ, 1'b1, 21'h0, 16'h0000);
      chk(16'h003c, got);
      op(FBH_OP_RESET, 1'b0, 21'h0, 16'h0000);
      op(FBH_OP_READ, 1'b0, 21'h000123, 16'h0000);
      chk(arr(21'h000123, 1'b0), got);
      $display("test autoselect reset done");
      op(FBH_OP_PROTECT, 1'b0, ad, 16'h0000);
      op(FBH_OP_UNPROTECT, 1'b0, ad, 16'h0000);
      chk(16'(i_flash.protCnt), 16'h0001);
      chk(16'(i_flash.unprotCnt), 16'h0001);
      chk(16'(i_flash.clash), 16'h0000);
      $display("test protect done");
      tally_and_finish();
   end
endmodule
